// ===== rtl/bsr_map.svh
// Register map, field positions and reset values of the setpoint and status registers
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH

`define BSR_ADDR_W         8
`define BSR_OFF_SETPOINT   8'h02
`define BSR_OFF_STATUS     8'h03
`define BSR_OFF_IRQ_STAT   8'h10
`define BSR_OFF_IRQ_MASK   8'h11
`define BSR_RST_SETPOINT   8'h00
`define BSR_RST_STATUS     8'h00
`define BSR_RST_MASK       8'h00
`define BSR_RST_EVENT      8'h00

`define BSR_BIT_WARN       7
`define BSR_BIT_ON         6
`define BSR_BIT_BOOT_ERR   5
`define BSR_BIT_RAMP_DONE  4
`define BSR_BIT_HICCUP     3
`define BSR_BIT_THERM      2
`define BSR_BIT_LATCH      1
`define BSR_BIT_PGOOD      0

`define BSR_CODE_FLOOR     8'h3b
`define BSR_CODE_FINE_LO   8'h3c
`define BSR_CODE_COARSE_LO 8'h80
`define BSR_MV_MIN         16'd600
`define BSR_MV_FINE_BASE   16'd610
`define BSR_MV_FINE_STEP   16'd10
`define BSR_MV_COARSE_BASE 16'd1300
`define BSR_MV_COARSE_STEP 16'd20

`endif

// ===== rtl/bsr_pkg.sv
// Types shared by the setpoint and status register block
package bsr_pkg;
  typedef struct packed {
    logic thermal_warning_flag;
    logic converter_on;
    logic boot_error;
    logic ramp_complete_flag;
    logic hiccup;
    logic thermal_fault_flag;
    logic latched_off;
    logic output_in_regulation;
  } bsr_status_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsr_req_t;
endpackage

// ===== rtl/bsr_regs.sv
// Setpoint code register, live status register and status-change interrupt
`include "bsr_map.svh"

module bsr_regs #(
  parameter int DATA_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire bsr_pkg::bsr_req_t   bus_req,
  output logic [DATA_W-1:0]        rdata,
  input  wire bsr_pkg::bsr_status_t cond,
  output logic [7:0]               target_level_code,
  output logic [15:0]              setpoint_mv,
  output logic                     irq
);
  import bsr_pkg::*;

  // Byte lanes are fixed by the register map; other widths cannot be served
  if (DATA_W != 8) begin : g_data_w_check
    $error("bsr_regs supports only 8-bit data");
  end

  // Header constants must agree with the decoder and the bus;
  // a bad edit there is refused here, not seen later as a wrong voltage
  localparam int FINE_TOP_MV   = int'(`BSR_MV_FINE_BASE) +
    (int'(`BSR_CODE_COARSE_LO) - int'(`BSR_CODE_FINE_LO) - 1) * int'(`BSR_MV_FINE_STEP);
  localparam int COARSE_TOP_MV = int'(`BSR_MV_COARSE_BASE) +
    (int'(8'hff) - int'(`BSR_CODE_COARSE_LO)) * int'(`BSR_MV_COARSE_STEP);
  localparam int BIT_SET       = (1 << `BSR_BIT_WARN) | (1 << `BSR_BIT_ON) |
    (1 << `BSR_BIT_BOOT_ERR) | (1 << `BSR_BIT_RAMP_DONE) | (1 << `BSR_BIT_HICCUP) |
    (1 << `BSR_BIT_THERM) | (1 << `BSR_BIT_LATCH) | (1 << `BSR_BIT_PGOOD);

  if (`BSR_ADDR_W != 8) begin : g_addr_w_check
    $error("bsr_regs expects an 8-bit register address");
  end

  if ($bits(bsr_req_t) != 2 + 2 * `BSR_ADDR_W) begin : g_req_w_check
    $error("bus request layout does not match the address width");
  end

  if ($bits(bsr_status_t) != 8) begin : g_status_w_check
    $error("status word must be one byte");
  end

  if (BIT_SET != 32'h0000_00ff) begin : g_bits_check
    $error("status bit positions must cover one byte exactly once");
  end

  if (`BSR_CODE_FINE_LO != `BSR_CODE_FLOOR + 8'h01) begin : g_floor_check
    $error("fine region must start right above the floor codes");
  end

  if (`BSR_CODE_COARSE_LO <= `BSR_CODE_FINE_LO) begin : g_region_check
    $error("coarse region must start above the fine region");
  end

  if (`BSR_MV_FINE_BASE <= `BSR_MV_MIN) begin : g_fine_base_check
    $error("first fine step must lie above the floor voltage");
  end

  if (FINE_TOP_MV >= int'(`BSR_MV_COARSE_BASE)) begin : g_monotonic_check
    $error("setpoint would step down between the fine and coarse regions");
  end

  if (COARSE_TOP_MV > 32'h0000_ffff) begin : g_mv_w_check
    $error("top setpoint does not fit the millivolt output");
  end

  if (`BSR_RST_SETPOINT > `BSR_CODE_FLOOR) begin : g_reset_code_check
    $error("reset code must decode to the floor setpoint");
  end

  if (`BSR_OFF_SETPOINT == `BSR_OFF_STATUS || `BSR_OFF_IRQ_STAT == `BSR_OFF_IRQ_MASK) begin : g_offset_check
    $error("two registers share one address");
  end

  if (`BSR_OFF_IRQ_STAT == `BSR_OFF_SETPOINT || `BSR_OFF_IRQ_STAT == `BSR_OFF_STATUS) begin : g_event_offset_check
    $error("event register overlaps a setpoint or status address");
  end

  if (`BSR_OFF_IRQ_MASK == `BSR_OFF_SETPOINT || `BSR_OFF_IRQ_MASK == `BSR_OFF_STATUS) begin : g_mask_offset_check
    $error("mask register overlaps a setpoint or status address");
  end

  // True when the request carries the given register address
  function automatic logic addr_is(
    input bsr_req_t               req,
    input logic [`BSR_ADDR_W-1:0] addr
  );
    return req.addr == addr;
  endfunction

  // Write strobe aimed at one register
  function automatic logic wr_hit(
    input bsr_req_t               req,
    input logic [`BSR_ADDR_W-1:0] addr
  );
    return req.wr && addr_is(req, addr);
  endfunction

  // Read strobe aimed at one register
  function automatic logic rd_hit(
    input bsr_req_t               req,
    input logic [`BSR_ADDR_W-1:0] addr
  );
    return req.rd && addr_is(req, addr);
  endfunction

  function automatic logic code_in_floor(
    input logic [7:0] code
  );
    return code <= `BSR_CODE_FLOOR;
  endfunction

  function automatic logic code_in_coarse(
    input logic [7:0] code
  );
    return code >= `BSR_CODE_COARSE_LO;
  endfunction

  // Millivolt setpoint of one code
  function automatic logic [15:0] code_to_mv(
    input logic [7:0] code
  );
    logic [15:0] mv;
    logic [7:0]  steps;
    mv    = `BSR_MV_MIN;
    steps = 8'h00;
    if (code_in_floor(code)) begin
      mv = `BSR_MV_MIN;
    end else if (code_in_coarse(code)) begin
      steps = code - `BSR_CODE_COARSE_LO;
      mv    = `BSR_MV_COARSE_BASE + 16'(steps) * `BSR_MV_COARSE_STEP;
    end else begin
      steps = code - `BSR_CODE_FINE_LO;
      mv    = `BSR_MV_FINE_BASE + 16'(steps) * `BSR_MV_FINE_STEP;
    end
    return mv;
  endfunction

  function automatic logic [7:0] status_word(
    input bsr_status_t s
  );
    logic [7:0] w;
    w                     = 8'h00;
    w[`BSR_BIT_WARN]      = s.thermal_warning_flag;
    w[`BSR_BIT_ON]        = s.converter_on;
    w[`BSR_BIT_BOOT_ERR]  = s.boot_error;
    w[`BSR_BIT_RAMP_DONE] = s.ramp_complete_flag;
    w[`BSR_BIT_HICCUP]    = s.hiccup;
    w[`BSR_BIT_THERM]     = s.thermal_fault_flag;
    w[`BSR_BIT_LATCH]     = s.latched_off;
    w[`BSR_BIT_PGOOD]     = s.output_in_regulation;
    return w;
  endfunction

  // Write-one-to-clear with a same-cycle set taking priority
  function automatic logic [7:0] sticky_next(
    input logic [7:0] held,
    input logic       clr_en,
    input logic [7:0] clr,
    input logic [7:0] set
  );
    logic [7:0] v;
    v = held;
    if (clr_en) begin
      v = v & ~clr;
    end
    // Set after clear so a same-cycle change survives
    return v | set;
  endfunction

  // Interrupt level of one event word under its mask
  function automatic logic masked_any(
    input logic [7:0] evt,
    input logic [7:0] mask
  );
    return |(evt & mask);
  endfunction

  // Setpoint code and its decoded value
  logic [7:0]  code_reg;
  logic [7:0]  code_next;
  logic [15:0] mv_reg;
  logic [15:0] mv_next;

  // Live status and its one-cycle history
  bsr_status_t stat_reg;
  bsr_status_t stat_next;
  bsr_status_t prev_reg;
  bsr_status_t prev_next;

  // Sticky events and their mask
  logic [7:0]  evt_reg;
  logic [7:0]  evt_next;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic [7:0]  change;

  // Registered bus answer and interrupt
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        irq_reg;
  logic        irq_next;

  // Setpoint code: plain read-write byte
  always_comb begin
    code_next = code_reg;
    if (wr_hit(bus_req, `BSR_OFF_SETPOINT)) begin
      code_next = bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= `BSR_RST_SETPOINT;
    end else begin
      code_reg <= code_next;
    end
  end

  // Decoded from the next code so code and millivolts change on one edge
  always_comb begin
    mv_next = code_to_mv(code_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset code lies in the floor region
      mv_reg <= `BSR_MV_MIN;
    end else begin
      mv_reg <= mv_next;
    end
  end

  // Status: conditions are levels, taken once per clock and never written
  always_comb begin
    stat_next = cond;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `BSR_RST_STATUS;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // History resets like the status, so no false event follows reset
  always_comb begin
    prev_next = stat_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= `BSR_RST_STATUS;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // Any edge of a status bit is an event
  assign change = status_word(stat_reg) ^ status_word(prev_reg);

  // Events: sticky, write one to clear
  always_comb begin
    evt_next = sticky_next(evt_reg, wr_hit(bus_req, `BSR_OFF_IRQ_STAT), bus_req.wdata, change);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= `BSR_RST_EVENT;
    end else begin
      evt_reg <= evt_next;
    end
  end

  // Mask: plain read-write byte, one bit per event
  always_comb begin
    mask_next = mask_reg;
    if (wr_hit(bus_req, `BSR_OFF_IRQ_MASK)) begin
      mask_next = bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `BSR_RST_MASK;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Read data stand for the one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (rd_hit(bus_req, `BSR_OFF_SETPOINT)) begin
      rdata_next = code_reg;
    end else if (rd_hit(bus_req, `BSR_OFF_STATUS)) begin
      rdata_next = status_word(stat_reg);
    end else if (rd_hit(bus_req, `BSR_OFF_IRQ_STAT)) begin
      rdata_next = evt_reg;
    end else if (rd_hit(bus_req, `BSR_OFF_IRQ_MASK)) begin
      rdata_next = mask_reg;
    end else begin
      // Holes and idle cycles read zero
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // From next-state values so the level follows event and mask on one edge
  always_comb begin
    irq_next = masked_any(evt_next, mask_next);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // Every output is a flop copy
  assign target_level_code = code_reg;
  assign setpoint_mv       = mv_reg;
  assign rdata             = rdata_reg;
  assign irq               = irq_reg;
endmodule

// ===== tb/bsr_chk.sv
// Checks on the register block ports
module bsr_chk (
  input logic                 clk,
  input logic                 rst_n,
  input bsr_pkg::bsr_req_t    bus_req,
  input logic [7:0]           rdata,
  input bsr_pkg::bsr_status_t cond,
  input logic [7:0]           target_level_code,
  input logic [15:0]          setpoint_mv);
  wire logic [15:0] c = 16'(target_level_code);
  wire logic [7:0]  a = bus_req.addr;
  wire logic        w = bus_req.wr, r = bus_req.rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_WR: assert property (w && a == 8'h02 |=> c[7:0] == $past(bus_req.wdata)) else $error("wr");
  AST_LO: assert property (c < 16'h3c |-> setpoint_mv == 16'd600) else $error("lo");
  AST_MID: assert property (c inside {[16'h3c:16'h7f]} |-> setpoint_mv == c * 16'd10 + 16'd10) else $error("mid");
  AST_HI: assert property (c > 16'h7f |-> setpoint_mv == c * 16'd20 - 16'd1260) else $error("hi");
  AST_ST: assert property (r && a == 8'h03 |=> rdata == $past(cond, 2)) else $error("st");
  AST_RB: assert property (r && a == 8'h02 |=> rdata == c[7:0]) else $error("rb");
  AST_IDLE: assert property (!$past(r) |-> rdata == 8'h00) else $error("idle");
  AST_RO: assert property (w && a != 8'h02 |=> $stable(c)) else $error("ro");
  cover property (c == 16'hff);
  cover property (w && a == 8'h03);
  cover property (r ##1 rdata != 8'h00);
endmodule
bind bsr_regs bsr_chk u_chk (.*);

// ===== tb/tb_top.sv
// Bench for the register block
module tb_top;
  timeunit 1ns / 1ns;
  import bsr_pkg::*;
  logic        clk = 0, rst_n = 0, irq;
  bsr_req_t    bus_req = '0;
  bsr_status_t cond = '0;
  logic [7:0]  rdata, target_level_code;
  logic [15:0] setpoint_mv;
  int          err_total = 0, num_checks = 0;
  bsr_regs uut (.*);
  always #5 clk = ~clk;
  task automatic chk(logic [15:0] g, e);
    num_checks++;
    err_total += int'(g !== e);
    if (g !== e) $display("BAD %0t %h %h", $time, g, e);
  endtask
  task automatic acc(logic w, logic [7:0] a, d);
    @(posedge clk) bus_req <= '{w, !w, a, d};
    @(posedge clk) bus_req <= '0;
    #1 if (!w) chk(rdata, d);
  endtask
  task automatic results(int x);
    err_total += x;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial #40000 results(1);
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    acc(1, 8'h03, 8'hff);
    acc(0, 8'h03, 8'h00);
    acc(0, 8'h40, 8'h00);
    for (int i = 0; i < 256; i++) begin
      acc(1, 8'h02, 8'(i));
      chk(target_level_code, 16'(i));
      chk(setpoint_mv, i <= 'h3b ? 600 : i < 'h80 ? 610 + (i - 'h3c) * 10 : 1300 + (i - 'h80) * 20);
      acc(0, 8'h02, 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) cond <= 8'h01 << i;
      acc(0, 8'h03, 8'h01 << i);
      acc(0, 8'h03, 8'h01 << i);
    end
    // Every bit has toggled, so all events stand
    @(posedge clk) cond <= 8'h81;
    #45 chk(irq, 0);
    acc(0, 8'h10, 8'hff);
    acc(1, 8'h11, 8'h01);
    #20 chk(irq, 1);
    acc(1, 8'h10, 8'h01);
    #20 chk(irq, 0);
    // Mid-run reset: registers return to their reset values
    @(posedge clk) rst_n <= 0;
    #1 chk(target_level_code, 16'h0000);
    chk(setpoint_mv, 16'd600);
    chk(rdata, 16'h0000);
    @(posedge clk) rst_n <= 1;
    acc(0, 8'h11, 8'h00);
    acc(0, 8'h03, 8'h81);
    results(0);
  end
endmodule
